// File: logic/ddr_sram_byte_write_mask.sv
`timescale 1ns/1ps
`default_nettype none

module ddr_sram_byte_write_mask
#(
   parameter int DATA_W = sram_mask_pkg::DATA_W_DEFAULT,
   parameter int ADDR_W = sram_mask_pkg::ADDR_W_DEFAULT,
   parameter int FIFO_DEPTH = sram_mask_pkg::FIFO_DEPTH_DEFAULT,
   parameter int LANES = sram_mask_pkg::lane_count(DATA_W)
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_load_cmd_n,
   input wire logic i_read_write,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic [LANES-1:0] i_lane_write_select_n,
   input wire logic i_single_clock_strap,
   output logic o_cmd_ready,
   output logic [DATA_W-1:0] o_rdata,
   output logic o_rdata_oe_n,
   output logic o_rvalid,
   output logic o_read_second_beat,
   output logic o_single_clock_mode
);

   localparam int WORDS = 2 ** ADDR_W;
   localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
   localparam int BEAT_W = $bits(sram_mask_pkg::write_beat_type);
   localparam logic [CNT_W-1:0] READY_LIMIT =
      CNT_W'(FIFO_DEPTH - sram_mask_pkg::READY_MARGIN);
   localparam logic [ADDR_W-1:0] STEP = ADDR_W'(sram_mask_pkg::BURST_STEP);

   sram_mask_pkg::pin_sample_type pin_reg;
   sram_mask_pkg::phase_type phase_reg;
   sram_mask_pkg::phase_type phase_next;
   sram_mask_pkg::write_beat_type push_beat;
   sram_mask_pkg::write_beat_type drain_beat;
   logic [ADDR_W-1:0] burst_addr_reg;
   logic [DATA_W-1:0] array_reg [WORDS];
   logic [sram_mask_pkg::DATA_MAX-1:0] beat_mask;
   logic [sram_mask_pkg::SYNC_STAGES-1:0] strap_sync_reg;
   logic [sram_mask_pkg::SYNC_STAGES-1:0] strap_fill_reg;
   logic strap_taken_reg;
   logic cmd_seen;
   logic cmd_slot;
   logic in_write_beat;
   logic in_read_beat;
   logic push_valid;
   logic push_ready;
   logic drain_valid;
   logic drain_ready;
   logic [BEAT_W-1:0] drain_bits;
   logic [CNT_W-1:0] fifo_count;
   logic [ADDR_W-1:0] beat_addr;

   function automatic logic [ADDR_W-1:0] burst_next(input logic [ADDR_W-1:0] a);
      burst_next = a + STEP;
   endfunction : burst_next

   // Every host signal is registered before the block looks at it.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pin_reg <= '0;
         pin_reg.load_cmd_n <= 1'b1;
         pin_reg.lane_write_select_n <= '1;
      end
      else
      begin
         pin_reg.load_cmd_n <= i_load_cmd_n;
         pin_reg.read_write <= i_read_write;
         pin_reg.cmd_allowed <= o_cmd_ready;
         pin_reg.addr <= sram_mask_pkg::ADDR_MAX'(i_addr);
         pin_reg.wdata <= sram_mask_pkg::DATA_MAX'(i_wdata);
         pin_reg.lane_write_select_n <=
            sram_mask_pkg::LANE_MAX'(i_lane_write_select_n) |
            ~sram_mask_pkg::LANE_MAX'({LANES{1'b1}});
      end
   end

   // A command is taken when idle or in the last beat of a burst.
   assign cmd_seen = !pin_reg.load_cmd_n && pin_reg.cmd_allowed;
   assign cmd_slot = (phase_reg == sram_mask_pkg::PH_IDLE) ||
                     (phase_reg == sram_mask_pkg::PH_WR_SECOND) ||
                     (phase_reg == sram_mask_pkg::PH_RD_SECOND);

   always_comb
   begin
      phase_next = sram_mask_pkg::PH_IDLE;
      case (phase_reg)
         sram_mask_pkg::PH_WR_FIRST:
         begin
            phase_next = sram_mask_pkg::PH_WR_SECOND;
         end
         sram_mask_pkg::PH_RD_FIRST:
         begin
            phase_next = sram_mask_pkg::PH_RD_SECOND;
         end
         default:
         begin
            if (cmd_slot && cmd_seen)
            begin
               phase_next = pin_reg.read_write ? sram_mask_pkg::PH_RD_FIRST
                                               : sram_mask_pkg::PH_WR_FIRST;
            end
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         phase_reg <= sram_mask_pkg::PH_IDLE;
      end
      else
      begin
         phase_reg <= phase_next;
      end
   end

   // The command address is latched for the whole burst.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         burst_addr_reg <= '0;
      end
      else if (cmd_slot && cmd_seen)
      begin
         burst_addr_reg <= pin_reg.addr[ADDR_W-1:0];
      end
   end

   assign in_write_beat = (phase_reg == sram_mask_pkg::PH_WR_FIRST) ||
                          (phase_reg == sram_mask_pkg::PH_WR_SECOND);
   assign in_read_beat = (phase_reg == sram_mask_pkg::PH_RD_FIRST) ||
                         (phase_reg == sram_mask_pkg::PH_RD_SECOND);
   assign beat_addr = (phase_reg == sram_mask_pkg::PH_WR_SECOND ||
                       phase_reg == sram_mask_pkg::PH_RD_SECOND)
                      ? burst_next(burst_addr_reg) : burst_addr_reg;

   // The mask is rebuilt from the selects of each beat on its own.
   lane_mask
   #(
      .DATA_W(DATA_W)
   )
   u_lane_mask
   (
      .i_lane_write_select_n(pin_reg.lane_write_select_n),
      .o_mask(beat_mask)
   );

   always_comb
   begin
      push_beat = '0;
      push_beat.addr = sram_mask_pkg::ADDR_MAX'(beat_addr);
      push_beat.data = pin_reg.wdata;
      push_beat.mask = beat_mask;
   end

   // A beat with no lane selected never reaches the array.
   assign push_valid = in_write_beat && (beat_mask != '0);

   beat_fifo
   #(
      .WIDTH(BEAT_W),
      .DEPTH(FIFO_DEPTH)
   )
   u_beat_fifo
   (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_valid(push_valid),
      .o_ready(push_ready),
      .i_data(push_beat),
      .o_valid(drain_valid),
      .i_ready(drain_ready),
      .o_data(drain_bits),
      .o_count(fifo_count)
   );

   assign drain_beat = sram_mask_pkg::write_beat_type'(drain_bits);

   // Reads own the array port; queued writes wait while a read beat runs.
   assign drain_ready = !in_read_beat;

   // Only the selected lanes of a word change; the others keep their data.
   always_ff @(posedge i_sys_clk)
   begin
      if (drain_valid && drain_ready)
      begin
         for (int b = 0; b < DATA_W; b++)
         begin
            if (drain_beat.mask[b])
            begin
               array_reg[drain_beat.addr[ADDR_W-1:0]][b] <= drain_beat.data[b];
            end
         end
      end
   end

   // New commands are held off while the queue could overflow.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_cmd_ready <= 1'b0;
      end
      else
      begin
         o_cmd_ready <= push_ready && (fifo_count <= READY_LIMIT);
      end
   end

   // Read words launch one per beat and the bus floats whenever no read beat runs; back-to-back read bursts keep it driven.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_rdata <= '0;
         o_rdata_oe_n <= 1'b1;
         o_rvalid <= 1'b0;
         o_read_second_beat <= 1'b0;
      end
      else
      begin
         o_rvalid <= in_read_beat;
         o_rdata_oe_n <= !in_read_beat;
         o_read_second_beat <= (phase_reg == sram_mask_pkg::PH_RD_SECOND);
         if (in_read_beat)
         begin
            o_rdata <= array_reg[beat_addr];
         end
      end
   end

   // The clock-mode strap is synchronised and caught once after reset.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         strap_sync_reg <= '0;
      end
      else
      begin
         strap_sync_reg <= {strap_sync_reg[sram_mask_pkg::SYNC_STAGES-2:0],
                            i_single_clock_strap};
      end
   end

   // The reset value of the chain is not the pin, so wait until the pin has reached its end.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         strap_fill_reg <= '0;
      end
      else
      begin
         strap_fill_reg <= {strap_fill_reg[sram_mask_pkg::SYNC_STAGES-2:0],
                            1'b1};
      end
   end

   // The value caught here stays until the next reset.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         strap_taken_reg <= 1'b0;
         o_single_clock_mode <= 1'b0;
      end
      else if (!strap_taken_reg &&
               strap_fill_reg[sram_mask_pkg::SYNC_STAGES-1] &&
               (strap_sync_reg[sram_mask_pkg::SYNC_STAGES-1] ==
                strap_sync_reg[sram_mask_pkg::SYNC_STAGES-2]))
      begin
         strap_taken_reg <= 1'b1;
         o_single_clock_mode <= strap_sync_reg[sram_mask_pkg::SYNC_STAGES-1];
      end
   end

endmodule : ddr_sram_byte_write_mask

`default_nettype wire

// File: inc/sram_mask_pkg.sv
package sram_mask_pkg;

   // Widest configuration and the largest address the carrier structs hold.
   localparam int DATA_MAX = 36;
   localparam int ADDR_MAX = 16;
   localparam int LANE_MAX = 4;

   // Lane geometry: the x8 part uses nibble lanes, all others 9-bit lanes.
   localparam int NIBBLE_DATA_W = 8;
   localparam int NIBBLE_LANE_BITS = 4;
   localparam int BYTE_LANE_BITS = 9;

   // Default configuration of the block.
   localparam int DATA_W_DEFAULT = 18;
   localparam int ADDR_W_DEFAULT = 8;
   localparam int FIFO_DEPTH_DEFAULT = 8;

   // Free FIFO slots needed before a new command is accepted.
   localparam int READY_MARGIN = 4;

   // Pin synchroniser length for the clock-mode strap.
   localparam int SYNC_STAGES = 3;

   // Internal address step between the two words of a burst.
   localparam int BURST_STEP = 1;

   typedef enum logic [2:0]
   {
      PH_IDLE = 3'h0,
      PH_WR_FIRST = 3'h1,
      PH_WR_SECOND = 3'h2,
      PH_RD_FIRST = 3'h3,
      PH_RD_SECOND = 3'h4
   } phase_type;

   typedef struct packed
   {
      logic load_cmd_n;
      logic read_write;
      logic cmd_allowed;
      logic [ADDR_MAX-1:0] addr;
      logic [DATA_MAX-1:0] wdata;
      logic [LANE_MAX-1:0] lane_write_select_n;
   } pin_sample_type;

   typedef struct packed
   {
      logic [ADDR_MAX-1:0] addr;
      logic [DATA_MAX-1:0] data;
      logic [DATA_MAX-1:0] mask;
   } write_beat_type;

   function automatic int lane_bits(input int data_w);
      lane_bits = (data_w == NIBBLE_DATA_W) ? NIBBLE_LANE_BITS : BYTE_LANE_BITS;
   endfunction : lane_bits

   function automatic int lane_count(input int data_w);
      lane_count = data_w / lane_bits(data_w);
   endfunction : lane_count

endpackage : sram_mask_pkg

// File: logic/lane_mask.sv
`timescale 1ns/1ps
`default_nettype none

module lane_mask
#(
   parameter int DATA_W = sram_mask_pkg::DATA_W_DEFAULT
)
(
   input wire logic [sram_mask_pkg::LANE_MAX-1:0] i_lane_write_select_n,
   output logic [sram_mask_pkg::DATA_MAX-1:0] o_mask
);

   localparam int LANE_W = sram_mask_pkg::lane_bits(DATA_W);
   localparam int LANES = sram_mask_pkg::lane_count(DATA_W);

   // Each data bit of a whole lane is enabled by the low select of that lane; bits past the last whole lane stay masked.
   always_comb
   begin
      o_mask = '0;
      for (int b = 0; b < DATA_W; b++)
      begin
         if ((b / LANE_W) < LANES)
         begin
            o_mask[b] = ~i_lane_write_select_n[b / LANE_W];
         end
      end
   end

endmodule : lane_mask

`default_nettype wire

// File: logic/beat_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module beat_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = sram_mask_pkg::FIFO_DEPTH_DEFAULT
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data,
   output logic [$clog2(DEPTH+1)-1:0] o_count
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_SLOT = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] store_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [CNT_W-1:0] count_reg;
   logic push;
   logic pop;

   assign o_ready = (count_reg != FULL_COUNT);
   assign o_valid = (count_reg != '0);
   assign o_data = store_reg[rd_ptr_reg];
   assign o_count = count_reg;
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   function automatic logic [PTR_W-1:0] advance(input logic [PTR_W-1:0] ptr);
      advance = (ptr == LAST_SLOT) ? '0 : ptr + 1'b1;
   endfunction : advance

   always_ff @(posedge i_sys_clk)
   begin
      if (push)
      begin
         store_reg[wr_ptr_reg] <= i_data;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= advance(wr_ptr_reg);
         end
         if (pop)
         begin
            rd_ptr_reg <= advance(rd_ptr_reg);
         end
         if (push && !pop)
         begin
            count_reg <= count_reg + 1'b1;
         end
         else if (pop && !push)
         begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule : beat_fifo

`default_nettype wire

// File: verif/mask_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mask_checker
#(
   parameter int DATA_W = 18
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_load_cmd_n,
   input wire logic i_read_write,
   input wire logic i_single_clock_strap,
   input wire logic o_cmd_ready,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic o_rdata_oe_n,
   input wire logic o_rvalid,
   input wire logic o_read_second_beat,
   input wire logic o_single_clock_mode
);
   logic busy_reg;
   logic [2:0] cnt_reg;
   logic take;
   logic rd_take;
   assign take = !i_load_cmd_n && o_cmd_ready && !busy_reg;
   assign rd_take = take && i_read_write;
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
         busy_reg <= 1'b0;
      else
         busy_reg <= take;
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
         cnt_reg <= 3'h0;
      else if (cnt_reg != 3'h7)
         cnt_reg <= cnt_reg + 3'h1;
   default clocking @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_word0;
      o_rvalid && !o_read_second_beat && !o_rdata_oe_n;
   endsequence
   sequence s_word1;
      o_rvalid && o_read_second_beat && !o_rdata_oe_n;
   endsequence
   a_read_latency: assert property (rd_take |-> ##3 s_word0 ##1 s_word1)
      else $error("read burst not at fixed latency");
   a_word_order: assert property (s_word0 |=> s_word1)
      else $error("second word missing");
   a_second_cause: assert property (o_read_second_beat |-> $past(o_rvalid))
      else $error("second word without first");
   a_word_cause: assert property (s_word0 |-> $past(rd_take, 3))
      else $error("read word without command");
   a_outputs_hiz: assert property (!o_rvalid |-> o_rdata_oe_n)
      else $error("read data driven while idle");
   a_oe_valid: assert property (o_rvalid |-> !o_rdata_oe_n)
      else $error("read word not driven");
   a_rdata_hold: assert property (!o_rvalid |-> $stable(o_rdata))
      else $error("read data changed while idle");
   a_mode_match: assert property (cnt_reg == 3'h7 |-> o_single_clock_mode == i_single_clock_strap)
      else $error("clock mode differs from strap");
   a_mode_fixed: assert property (cnt_reg == 3'h7 |=> $stable(o_single_clock_mode))
      else $error("clock mode changed");
endmodule : mask_checker
bind ddr_sram_byte_write_mask mask_checker #(.DATA_W(DATA_W)) chk_u (.i_sys_clk, .i_rst_n,
   .i_load_cmd_n, .i_read_write, .i_single_clock_strap, .o_cmd_ready, .o_rdata,
   .o_rdata_oe_n, .o_rvalid, .o_read_second_beat, .o_single_clock_mode);
`default_nettype wire

// File: verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 18,
   parameter int LANES = 2
)
(
   input wire logic i_sys_clk,
   input wire logic i_cmd_ready,
   output logic o_load_cmd_n,
   output logic o_read_write,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_wdata,
   output logic [LANES-1:0] o_sel_n,
   output logic o_stuck
);
   initial
   begin
      o_load_cmd_n = 1'b1;
      o_read_write = 1'b1;
      o_addr = '0;
      o_wdata = '0;
      o_sel_n = '1;
      o_stuck = 1'b0;
   end
   task automatic command(input logic rw, input logic [ADDR_W-1:0] a);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      while (i_cmd_ready !== 1'b1 && n < 100)
      begin
         @(posedge i_sys_clk);
         n++;
      end
      if (n == 100)
         o_stuck = 1'b1;
      o_load_cmd_n <= 1'b0;
      o_read_write <= rw;
      o_addr <= a;
      @(posedge i_sys_clk);
      o_load_cmd_n <= 1'b1;
      o_addr <= ~a;
   endtask : command
   task automatic write_burst(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0,
      input logic [DATA_W-1:0] d1, input logic [LANES-1:0] s0, input logic [LANES-1:0] s1);
      command(1'b0, a);
      o_wdata <= d0;
      o_sel_n <= s0;
      @(posedge i_sys_clk);
      o_wdata <= d1;
      o_sel_n <= s1;
      @(posedge i_sys_clk);
      o_wdata <= ~d1;
      o_sel_n <= ~s1;
   endtask : write_burst
endmodule : host_model
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic load_n, rw, cmd_ready, oe_n, rvalid, second, mode, stuck;
   logic rdy8, rdy9, rdy36, all_ready, mode9;
   logic [7:0] addr;
   logic [35:0] wdata, rdata36;
   logic [17:0] rdata;
   logic [7:0] rdata8;
   logic [8:0] rdata9;
   logic [3:0] sel_n;
   logic [17:0] mem [256];
   logic [7:0] mem8 [256];
   logic [8:0] mem9 [256];
   logic [35:0] mem36 [256];
   int failures = 0;
   int checked = 0;
   always #5 clk = ~clk;
   assign all_ready = cmd_ready && rdy8 && rdy9 && rdy36;
   ddr_sram_byte_write_mask dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_load_cmd_n(load_n),
      .i_read_write(rw), .i_addr(addr), .i_wdata(wdata[17:0]),
      .i_lane_write_select_n(sel_n[1:0]), .i_single_clock_strap(1'b1),
      .o_cmd_ready(cmd_ready), .o_rdata(rdata), .o_rdata_oe_n(oe_n), .o_rvalid(rvalid),
      .o_read_second_beat(second), .o_single_clock_mode(mode));
   ddr_sram_byte_write_mask #(.DATA_W(8)) dut_u8 (.i_sys_clk(clk), .i_rst_n(rst_n),
      .i_load_cmd_n(load_n), .i_read_write(rw), .i_addr(addr), .i_wdata(wdata[7:0]),
      .i_lane_write_select_n(sel_n[1:0]), .i_single_clock_strap(1'b1), .o_cmd_ready(rdy8),
      .o_rdata(rdata8), .o_rdata_oe_n(), .o_rvalid(), .o_read_second_beat(),
      .o_single_clock_mode());
   ddr_sram_byte_write_mask #(.DATA_W(9)) dut_u9 (.i_sys_clk(clk), .i_rst_n(rst_n),
      .i_load_cmd_n(load_n), .i_read_write(rw), .i_addr(addr), .i_wdata(wdata[8:0]),
      .i_lane_write_select_n(sel_n[0:0]), .i_single_clock_strap(1'b0), .o_cmd_ready(rdy9),
      .o_rdata(rdata9), .o_rdata_oe_n(), .o_rvalid(), .o_read_second_beat(),
      .o_single_clock_mode(mode9));
   ddr_sram_byte_write_mask #(.DATA_W(36)) dut_u36 (.i_sys_clk(clk), .i_rst_n(rst_n),
      .i_load_cmd_n(load_n), .i_read_write(rw), .i_addr(addr), .i_wdata(wdata),
      .i_lane_write_select_n(sel_n), .i_single_clock_strap(1'b1), .o_cmd_ready(rdy36),
      .o_rdata(rdata36), .o_rdata_oe_n(), .o_rvalid(), .o_read_second_beat(),
      .o_single_clock_mode());
   host_model #(.DATA_W(36), .LANES(4)) host_u (.i_sys_clk(clk), .i_cmd_ready(all_ready),
      .o_load_cmd_n(load_n), .o_read_write(rw), .o_addr(addr), .o_wdata(wdata),
      .o_sel_n(sel_n), .o_stuck(stuck));
   task automatic print_verdict();
      if (stuck === 1'b1)
         failures++;
      if (failures == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask : check
   task automatic put(input logic [7:0] a, input logic [35:0] d, input logic [3:0] s);
      for (int l = 0; l < 4; l++)
         if (!s[l])
         begin
            mem36[a][l*9+:9] = d[l*9+:9];
            if (l < 2)
            begin
               mem[a][l*9+:9] = d[l*9+:9];
               mem8[a][l*4+:4] = d[l*4+:4];
            end
            if (l == 0)
               mem9[a] = d[8:0];
         end
   endtask : put
   task automatic do_write(input logic [7:0] a, input logic [35:0] d0, input logic [35:0] d1,
      input logic [3:0] s0, input logic [3:0] s1);
      host_u.write_burst(a, d0, d1, s0, s1);
      if (stuck === 1'b1)
         print_verdict();
      put(a, d0, s0);
      put(a + 8'h1, d1, s1);
   endtask : do_write
   task automatic do_read(input logic [7:0] a);
      logic [7:0] b;
      b = a + 8'h1;
      repeat (12) @(posedge clk);
      host_u.command(1'b1, a);
      if (stuck === 1'b1)
         print_verdict();
      repeat (2) @(posedge clk);
      #1;
      check(rvalid && !oe_n && !second, 36'h1, "first word flags");
      check(rdata, mem[a], "first word data");
      check(rdata8, mem8[a], "first nibble word");
      check(rdata9, mem9[a], "first single lane word");
      check(rdata36, mem36[a], "first four lane word");
      @(posedge clk);
      #1;
      check(rvalid && second, 36'h1, "second word flags");
      check(rdata, mem[b], "second word data");
      check(rdata8, mem8[b], "second nibble word");
      check(rdata9, mem9[b], "second single lane word");
      check(rdata36, mem36[b], "second four lane word");
   endtask : do_read
   task automatic t_reset_state();
      check(cmd_ready, 36'h1, "not ready after reset");
      check(oe_n, 36'h1, "outputs driven after reset");
      check(rvalid, 36'h0, "read valid after reset");
   endtask : t_reset_state
   task automatic t_full_write();
      do_write(8'h10, 36'h2a5c3e817, 36'h15a3c7e29, 4'h0, 4'h0);
      do_read(8'h10);
   endtask : t_full_write
   task automatic t_lane_selects();
      for (int v = 0; v < 4; v++)
      begin
         do_write(8'h10, 36'h30f0f0f0f ^ {9{v[3:0]}}, 36'hc30303030, {2{v[1:0]}},
            {2{~v[1:0]}});
         do_read(8'h10);
      end
   endtask : t_lane_selects
   task automatic t_wrap();
      do_write(8'hff, 36'h1c3a5d0e6, 36'h0bd42f719, 4'h0, 4'h0);
      do_read(8'hff);
   endtask : t_wrap
   task automatic t_widths();
      for (int v = 0; v < 16; v++)
      begin
         do_write(8'h10, 36'h5a0f3c96e ^ {9{v[3:0]}}, 36'ha5f0c3691, v[3:0],
            ~v[3:0]);
         do_read(8'h10);
      end
   endtask : t_widths
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      t_reset_state();
      t_full_write();
      t_lane_selects();
      t_wrap();
      t_widths();
      check(mode, 36'h1, "clock mode strap");
      check(mode9, 36'h0, "clock mode without strap");
      print_verdict();
   end
endmodule : tb
`default_nettype wire
